// File: sfb_front_end.sv
`timescale 1ns/10ps
`include "sfb_consts.svh"

module sfb_front_end
    import sfb_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic chip_select_n_in,
    input wire logic serial_clock_in,
    input wire logic data_line_0_in,
    input wire logic data_line_1_in,
    input wire logic data_line_2_in,
    input wire logic data_line_3_in,
    output logic data_line_0_out,
    output logic data_line_1_out,
    output logic data_line_2_out,
    output logic data_line_3_out,
    output logic data_line_0_oe_out,
    output logic data_line_1_oe_out,
    output logic data_line_2_oe_out,
    output logic data_line_3_oe_out,
    input wire logic quad_enable_bit_in,
    input wire logic status_protect_bit_in,
    input wire logic write_enable_latch_in,
    input wire logic out_phase_in,
    input wire logic [7:0] tx_byte_in,
    output logic cmd_valid_out,
    output logic [7:0] cmd_byte_out,
    output logic rx_valid_out,
    output logic [7:0] rx_byte_out,
    output logic tx_take_out,
    output logic four_wire_command_mode_out,
    output logic soft_reset_out,
    output logic selected_out,
    output logic paused_out,
    output logic sr_write_allow_out
);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------

    // Bits moved per clock for a lane setting
    function automatic logic [3:0] lane_bits(input sfb_lane_t ln);
        case (ln)
            ln_x2: lane_bits = `SFB_BITS_X2;
            ln_x4: lane_bits = `SFB_BITS_X4;
            default: lane_bits = `SFB_BITS_X1;
        endcase
    endfunction

    // Shift left by the lane width, new bits enter at the bottom
    function automatic logic [7:0] lane_shift(input logic [7:0] sh,
                                              input sfb_lane_t ln,
                                              input logic [3:0] din);
        case (ln)
            ln_x2: lane_shift = {sh[5:0], din[1:0]};
            ln_x4: lane_shift = {sh[3:0], din};
            default: lane_shift = {sh[6:0], din[0]};
        endcase
    endfunction

    // Top bits of a shifter placed on the lines
    function automatic logic [3:0] lane_drive(input logic [7:0] sh,
                                              input sfb_lane_t ln);
        case (ln)
            ln_x2: lane_drive = {2'h0, sh[7:6]};
            ln_x4: lane_drive = sh[7:4];
            default: lane_drive = {2'h0, sh[7], 1'h0};
        endcase
    endfunction

    // Output enables for a lane setting
    function automatic logic [3:0] lane_oe(input sfb_lane_t ln);
        case (ln)
            ln_x2: lane_oe = `SFB_OE_X2;
            ln_x4: lane_oe = `SFB_OE_X4;
            default: lane_oe = `SFB_OE_X1;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    logic [`SFB_SYNC_W-1:0] pin_lvl; // Filtered pin levels
    logic cs_lvl; // Select level, high is deselected
    logic clk_lvl; // Serial clock level
    logic wp_lvl; // Line two read as protect pin
    logic pause_lvl; // Line three read as pause pin
    logic [3:0] din; // All four data lines

    sfb_sync u_sync (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .pins_in({data_line_3_in, data_line_2_in, data_line_1_in,
                  data_line_0_in, serial_clock_in, chip_select_n_in}),
        .level_out(pin_lvl)
    );

    assign cs_lvl = pin_lvl[`SFB_PIN_CS];
    assign clk_lvl = pin_lvl[`SFB_PIN_CLK];
    assign wp_lvl = pin_lvl[`SFB_PIN_D2];
    assign pause_lvl = pin_lvl[`SFB_PIN_D3];
    assign din = pin_lvl[`SFB_PIN_D3:`SFB_PIN_D0];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    sfb_regs_t q_reg; // Registered state
    sfb_regs_t q_next; // Next state
    logic cs_fall; // Select just went low
    logic clk_rise; // Serial clock rising edge
    logic clk_fall; // Serial clock falling edge
    logic pause_en; // Pause pin has its pause meaning
    logic active; // Selected and not paused
    logic [3:0] rx_sum; // Received bit count after this clock
    logic [7:0] rx_new; // Receive shifter after this clock
    logic tx_now; // Output step on this falling edge

    // Decode edges, pause, shifting and mode changes
    always_comb begin
        q_next = q_reg;
        q_next.cmd_v = 1'b0;
        q_next.rx_v = 1'b0;
        q_next.take = 1'b0;
        q_next.srst = 1'b0;
        q_next.cs_q = cs_lvl;
        q_next.clk_q = clk_lvl;
        cs_fall = q_reg.cs_q & ~cs_lvl;
        clk_rise = ~q_reg.clk_q & clk_lvl;
        clk_fall = q_reg.clk_q & ~clk_lvl;
        rx_sum = 4'(q_reg.rx_cnt + lane_bits(q_reg.in_lane));
        rx_new = lane_shift(q_reg.rx_sh, q_reg.in_lane, din);
        tx_now = 1'b0;
        // Pause pin is a data line under quad enable or four wire
        pause_en = ~quad_enable_bit_in & ~q_reg.four_wire_command_mode;
        active = q_reg.sel & ~cs_lvl & ~q_reg.paused;

        // Arm only after a real high level on select
        if (cs_lvl) begin
            q_next.seen_high = 1'b1;
        end

        // Pause follows the pin while selected, pause enabled and the clock sits low
        if (cs_lvl || !pause_en || !q_reg.sel) begin
            q_next.paused = 1'b0;
        end else if (!clk_lvl) begin
            q_next.paused = ~pause_lvl;
        end

        if (cs_lvl) begin
            // Deselect: drop the instruction, keep engine cycles
            q_next.sel = 1'b0;
            q_next.ph = ph_idle;
            q_next.rx_cnt = 4'h0;
            q_next.tx_cnt = 4'h0;
        end else if (cs_fall && q_reg.seen_high) begin
            // New selection, opcode width set by the command mode
            q_next.sel = 1'b1;
            q_next.ph = ph_cmd;
            q_next.rx_cnt = 4'h0;
            q_next.tx_cnt = 4'h0;
            q_next.in_lane = q_reg.four_wire_command_mode ? ln_x4 : ln_x1;
            q_next.out_lane = q_reg.four_wire_command_mode ? ln_x4 : ln_x1;
        end else if (active) begin
            // Inputs sampled on rising edges, either idle level
            if (clk_rise && !out_phase_in &&
                (q_reg.ph == ph_cmd || q_reg.ph == ph_body)) begin
                q_next.rx_sh = rx_new;
                q_next.rx_cnt = rx_sum;
                if (rx_sum == `SFB_BYTE_BITS) begin
                    q_next.rx_cnt = 4'h0;
                    if (q_reg.ph == ph_cmd) begin
                        q_next.cmd_v = 1'b1;
                        q_next.cmd = rx_new;
                        q_next.ph = ph_body;
                        // Mode and width switching opcodes
                        case (rx_new)
                            `SFB_OP_ENTER_QPI: begin
                                if (quad_enable_bit_in) begin
                                    q_next.four_wire_command_mode = 1'b1;
                                end
                            end
                            `SFB_OP_EXIT_QPI: begin
                                q_next.four_wire_command_mode = 1'b0;
                            end
                            `SFB_OP_SW_RESET: begin
                                q_next.four_wire_command_mode = 1'b0;
                                q_next.srst = 1'b1;
                            end
                            `SFB_OP_DUAL_OUT: begin
                                if (!q_reg.four_wire_command_mode) begin
                                    q_next.out_lane = ln_x2;
                                end
                            end
                            `SFB_OP_DUAL_IO: begin
                                if (!q_reg.four_wire_command_mode) begin
                                    q_next.in_lane = ln_x2;
                                    q_next.out_lane = ln_x2;
                                end
                            end
                            `SFB_OP_QUAD_OUT: begin
                                if (!quad_enable_bit_in) begin
                                    q_next.cmd_v = 1'b0;
                                    q_next.ph = ph_skip;
                                end else begin
                                    q_next.out_lane = ln_x4;
                                end
                            end
                            `SFB_OP_QUAD_IO: begin
                                if (!quad_enable_bit_in) begin
                                    q_next.cmd_v = 1'b0;
                                    q_next.ph = ph_skip;
                                end else begin
                                    q_next.in_lane = ln_x4;
                                    q_next.out_lane = ln_x4;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end else begin
                        // Address or write data byte
                        q_next.rx_v = 1'b1;
                        q_next.rx = rx_new;
                    end
                end
            end
            // Outputs change on falling edges only
            if (clk_fall && out_phase_in && q_reg.ph == ph_body) begin
                tx_now = 1'b1;
                if (q_reg.tx_cnt == 4'h0) begin
                    q_next.take = 1'b1;
                    q_next.d_out = lane_drive(tx_byte_in,
                                              q_reg.out_lane);
                    q_next.tx_sh = lane_shift(tx_byte_in,
                                              q_reg.out_lane, 4'h0);
                    q_next.tx_cnt = 4'(`SFB_BYTE_BITS -
                                       lane_bits(q_reg.out_lane));
                end else begin
                    q_next.d_out = lane_drive(q_reg.tx_sh,
                                              q_reg.out_lane);
                    q_next.tx_sh = lane_shift(q_reg.tx_sh,
                                              q_reg.out_lane, 4'h0);
                    q_next.tx_cnt = 4'(q_reg.tx_cnt -
                                       lane_bits(q_reg.out_lane));
                end
            end
        end

        // Release lines when deselected, paused or not sending
        if (cs_lvl || q_next.paused || !out_phase_in ||
            q_next.ph != ph_body) begin
            q_next.d_oe = 4'h0;
        end else if (tx_now) begin
            q_next.d_oe = lane_oe(q_reg.out_lane);
        end

        // Status write permission, protect pin lost under quad
        q_next.allow = write_enable_latch_in &
                       ~(status_protect_bit_in & ~wp_lvl &
                         ~quad_enable_bit_in);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------

    // Reset leaves serial command mode and released lines
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign data_line_0_out = q_reg.d_out[0];
    assign data_line_1_out = q_reg.d_out[1];
    assign data_line_2_out = q_reg.d_out[2];
    assign data_line_3_out = q_reg.d_out[3];
    assign data_line_0_oe_out = q_reg.d_oe[0];
    assign data_line_1_oe_out = q_reg.d_oe[1];
    assign data_line_2_oe_out = q_reg.d_oe[2];
    assign data_line_3_oe_out = q_reg.d_oe[3];
    assign cmd_valid_out = q_reg.cmd_v;
    assign cmd_byte_out = q_reg.cmd;
    assign rx_valid_out = q_reg.rx_v;
    assign rx_byte_out = q_reg.rx;
    assign tx_take_out = q_reg.take;
    assign four_wire_command_mode_out = q_reg.four_wire_command_mode;
    assign soft_reset_out = q_reg.srst;
    assign selected_out = q_reg.sel;
    assign paused_out = q_reg.paused;
    assign sr_write_allow_out = q_reg.allow;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------

    // Select high releases every line on the next edge
    property p_desel_release;
        @(posedge clk_in) disable iff (!rstn_in)
        cs_lvl |=> (q_reg.d_oe == 4'h0) && !q_reg.sel;
    endproperty
    a_desel_release: assert property (p_desel_release)
        else $error("lines driven while deselected");

    // No command seen before a valid selection
    property p_no_cmd_unarmed;
        @(posedge clk_in) disable iff (!rstn_in)
        !q_reg.seen_high |-> ##1 !q_reg.cmd_v;
    endproperty
    a_no_cmd_unarmed: assert property (p_no_cmd_unarmed)
        else $error("command taken before select fell");

    // Quad instructions only reported with quad enable
    property p_quad_needs_qe;
        @(posedge clk_in) disable iff (!rstn_in)
        q_reg.cmd_v && (q_reg.cmd == `SFB_OP_QUAD_IO ||
                        q_reg.cmd == `SFB_OP_QUAD_OUT)
            |-> $past(quad_enable_bit_in);
    endproperty
    a_quad_needs_qe: assert property (p_quad_needs_qe)
        else $error("quad command without quad enable");

    // Protect pin low with protect bit blocks status writes while quad enable is clear
    property p_wp_blocks;
        @(posedge clk_in) disable iff (!rstn_in)
        status_protect_bit_in && !wp_lvl && !quad_enable_bit_in
            |=> !sr_write_allow_out;
    endproperty
    a_wp_blocks: assert property (p_wp_blocks)
        else $error("status write allowed while protected");

    // Protect bit clear: latch alone decides
    property p_latch_allows;
        @(posedge clk_in) disable iff (!rstn_in)
        !status_protect_bit_in && write_enable_latch_in
            |=> sr_write_allow_out;
    endproperty
    a_latch_allows: assert property (p_latch_allows)
        else $error("status write refused with latch set");

    // Exit and reset opcodes leave serial command mode
    property p_exit_mode;
        @(posedge clk_in) disable iff (!rstn_in)
        q_reg.cmd_v && (q_reg.cmd == `SFB_OP_EXIT_QPI ||
                        q_reg.cmd == `SFB_OP_SW_RESET)
            |-> !q_reg.four_wire_command_mode;
    endproperty
    a_exit_mode: assert property (p_exit_mode)
        else $error("four wire mode kept after exit");

    // Four wire mode entered only with quad enable
    property p_qpi_entry;
        @(posedge clk_in) disable iff (!rstn_in)
        $rose(q_reg.four_wire_command_mode) |-> $past(quad_enable_bit_in);
    endproperty
    a_qpi_entry: assert property (p_qpi_entry)
        else $error("four wire mode without quad enable");

    // Quad enable removes the pause within one edge
    property p_no_pause_qe;
        @(posedge clk_in) disable iff (!rstn_in)
        quad_enable_bit_in |=> !q_reg.paused;
    endproperty
    a_no_pause_qe: assert property (p_no_pause_qe)
        else $error("pause active under quad enable");

    // Paused device keeps all lines released
    property p_pause_release;
        @(posedge clk_in) disable iff (!rstn_in)
        q_reg.paused |-> q_reg.d_oe == 4'h0;
    endproperty
    a_pause_release: assert property (p_pause_release)
        else $error("lines driven while paused");

    // Deselect clears counters and phase
    property p_desel_clear;
        @(posedge clk_in) disable iff (!rstn_in)
        $rose(cs_lvl) |=> q_reg.rx_cnt == 4'h0 &&
                          q_reg.tx_cnt == 4'h0 && q_reg.ph == ph_idle;
    endproperty
    a_desel_clear: assert property (p_desel_clear)
        else $error("instruction state kept after deselect");

endmodule

// File: sfb_consts.svh
`ifndef SFB_CONSTS_SVH
`define SFB_CONSTS_SVH

// ----------------------------------------------------------------
// Instruction codes handled by the front end
// ----------------------------------------------------------------
`define SFB_OP_DUAL_OUT 8'h3b
`define SFB_OP_DUAL_IO 8'hbb
`define SFB_OP_QUAD_OUT 8'h6b
`define SFB_OP_QUAD_IO 8'heb
`define SFB_OP_ENTER_QPI 8'h38
`define SFB_OP_EXIT_QPI 8'hff
`define SFB_OP_SW_RESET 8'h99

// ----------------------------------------------------------------
// Synchroniser layout: bit position of each sampled pin
// ----------------------------------------------------------------
`define SFB_SYNC_W 6
`define SFB_PIN_CS 0
`define SFB_PIN_CLK 1
`define SFB_PIN_D0 2
`define SFB_PIN_D2 4
`define SFB_PIN_D3 5
// Select reads low at reset so a real high must be seen first
`define SFB_SYNC_RST 6'h3c

// ----------------------------------------------------------------
// Shift counts and output enable patterns
// ----------------------------------------------------------------
`define SFB_BYTE_BITS 4'h8
`define SFB_BITS_X1 4'h1
`define SFB_BITS_X2 4'h2
`define SFB_BITS_X4 4'h4
`define SFB_OE_X1 4'h2
`define SFB_OE_X2 4'h3
`define SFB_OE_X4 4'hf

`endif

// File: sfb_pkg.sv
`include "sfb_consts.svh"

package sfb_pkg;

    // ------------------------------------------------------------
    // Phase of the current selection
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ph_idle = 2'b00,
        ph_cmd = 2'b01,
        ph_body = 2'b10,
        ph_skip = 2'b11
    } sfb_phase_t;

    // ------------------------------------------------------------
    // Number of data lines used per clock
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ln_x1 = 2'b00,
        ln_x2 = 2'b01,
        ln_x4 = 2'b10
    } sfb_lane_t;

    // ------------------------------------------------------------
    // State of the pin synchroniser
    // ------------------------------------------------------------
    typedef struct packed {
        logic [`SFB_SYNC_W-1:0] s1;
        logic [`SFB_SYNC_W-1:0] s2;
        logic [`SFB_SYNC_W-1:0] s3;
        logic [`SFB_SYNC_W-1:0] lvl;
    } sfb_sync_t;

    // ------------------------------------------------------------
    // State of the bus front end
    // ------------------------------------------------------------
    typedef struct packed {
        logic cs_q;
        logic clk_q;
        logic seen_high;
        logic sel;
        sfb_phase_t ph;
        sfb_lane_t in_lane;
        sfb_lane_t out_lane;
        logic [7:0] rx_sh;
        logic [3:0] rx_cnt;
        logic [7:0] tx_sh;
        logic [3:0] tx_cnt;
        logic four_wire_command_mode;
        logic paused;
        logic [3:0] d_out;
        logic [3:0] d_oe;
        logic cmd_v;
        logic [7:0] cmd;
        logic rx_v;
        logic [7:0] rx;
        logic take;
        logic srst;
        logic allow;
    } sfb_regs_t;

endpackage

// File: sfb_sync.sv
`timescale 1ns/10ps
`include "sfb_consts.svh"

module sfb_sync
    import sfb_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [`SFB_SYNC_W-1:0] pins_in,
    output logic [`SFB_SYNC_W-1:0] level_out
);

    // ------------------------------------------------------------
    // Three stage chain with agreement filter
    // ------------------------------------------------------------
    sfb_sync_t q_reg; // Registered state
    sfb_sync_t q_next; // Next state
    logic [`SFB_SYNC_W-1:0] agree; // Second and third stage match

    // Level follows a bit only once stages two and three agree
    always_comb begin
        agree = ~(q_reg.s2 ^ q_reg.s3);
        q_next = q_reg;
        q_next.s1 = pins_in;
        q_next.s2 = q_reg.s1;
        q_next.s3 = q_reg.s2;
        q_next.lvl = (q_reg.s2 & agree) | (q_reg.lvl & ~agree);
    end

    // Register the chain
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            q_reg <= sfb_sync_t'({4{`SFB_SYNC_RST}});
        end else begin
            q_reg <= q_next;
        end
    end

    assign level_out = q_reg.lvl;

endmodule

// File: sfb_host.sv
`timescale 1ns/10ps
// ----
// Host controller: select, serial clock, lines
// ----
module sfb_host (
    output logic cs_n_out,
    output logic sclk_out,
    output logic [3:0] d_out,
    input wire logic [3:0] d_in
);
    localparam int H = 200; // Half period, kept above sync delay
    logic m3 = 1'b0; // Clock idles high in mode 3
    logic hold = 1'b0; // Pause once inside next byte
    // Select low but never seen high yet
    initial begin
        cs_n_out = 1'b0;
        sclk_out = 1'b0;
        d_out = 4'hc; // Protect and pause pins idle high
    end
    // Select high, then low to arm the device
    task open;
        sclk_out = m3;
        #(2*H) cs_n_out = 1'b1;
        #(2*H) cs_n_out = 1'b0;
        #(2*H);
    endtask
    // Clock parked at idle level, select raised, lines let go
    task close;
        #H sclk_out = m3;
        #(2*H) cs_n_out = 1'b1;
        d_out = {2'b11, ~d_out[1:0]};
        #(2*H);
    endtask
    // One byte MSB first over w lines; rd inverts host lines 0-1, or all four when w is 4
    task xfer(input logic [7:0] b, input int w, input bit rd,
              output logic [7:0] r);
        r = 8'h00;
        for (int i = 0; i < 8 / w; i++) begin
            sclk_out = 1'b0; // Change data after falling edge
            if (rd)
                d_out = (w == 4) ? ~d_out : {d_out[3:2], ~d_out[1:0]};
            else if (w == 1)
                d_out[0] = b[7];
            else if (w == 2)
                d_out[1:0] = b[7:6];
            else
                d_out = b[7:4];
            b = b << w;
            #H sclk_out = 1'b1;
            r = (w == 4) ? {r[3:0], d_in} : (w == 2) ?
                {r[5:0], d_in[1:0]} : {r[6:0], d_in[1]};
            if (hold && i == 3) begin
                #H sclk_out = 1'b0;
                d_out[3] = 1'b0; // Pause with clock low
                repeat (4) #H sclk_out = ~sclk_out;
                d_out[3] = 1'b1;
                hold = 1'b0;
            end
            #H;
        end
    endtask
endmodule

// File: testbench.sv
`timescale 1ns/10ps
module testbench;
    // ----
    // Signals, expected queues, counters
    // ----
    logic clk_in, rstn_in, quad_en, spb, wel, oph, seen_p;
    logic [7:0] txb, r, b;
    logic [7:0] eq[$], rq[$]; // Expected opcodes and body bytes
    logic [7:0] ops[4] = '{8'h3b, 8'hbb, 8'h6b, 8'heb};
    logic [31:0] seed = 32'd33768;
    wire [3:0] hd, dout, doe, dq;
    wire cs_n, sclk, mode, cmd_v, rx_v, srst, pau, allow, take, sel;
    wire [7:0] cmd_b, rx_b;
    int n_mismatch = 0, n_tests = 0, cyc = 0, nsr = 0, ntk = 0;
    assign dq = (doe & dout) | (~doe & hd); // Wire level for both
    sfb_host i_sfb_host (.cs_n_out(cs_n), .sclk_out(sclk), .d_out(hd),
        .d_in(dq));
    sfb_front_end i_sfb_front_end (
        .clk_in, .rstn_in, .chip_select_n_in(cs_n), .serial_clock_in(sclk),
        .data_line_0_in(dq[0]), .data_line_1_in(dq[1]),
        .data_line_2_in(dq[2]), .data_line_3_in(dq[3]),
        .data_line_0_out(dout[0]), .data_line_1_out(dout[1]),
        .data_line_2_out(dout[2]), .data_line_3_out(dout[3]),
        .data_line_0_oe_out(doe[0]), .data_line_1_oe_out(doe[1]),
        .data_line_2_oe_out(doe[2]), .data_line_3_oe_out(doe[3]),
        .quad_enable_bit_in(quad_en), .status_protect_bit_in(spb),
        .write_enable_latch_in(wel), .out_phase_in(oph), .tx_byte_in(txb),
        .cmd_valid_out(cmd_v), .cmd_byte_out(cmd_b), .rx_valid_out(rx_v),
        .rx_byte_out(rx_b), .tx_take_out(take), .soft_reset_out(srst),
        .four_wire_command_mode_out(mode), .selected_out(sel),
        .paused_out(pau), .sr_write_allow_out(allow));
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    function automatic logic [7:0] rnd;
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task conclude;
        $display("mismatches %0d tests %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Select, then an opcode that must be honoured
    task go(input logic [7:0] c, input int w);
        eq.push_back(c);
        i_sfb_host.open;
        i_sfb_host.xfer(c, w, 1'b0, r);
    endtask
    task op(input logic [7:0] c, input int w);
        go(c, w);
        i_sfb_host.close;
    endtask
    // Read one byte over w lines, then deselect
    task rd(input int w, input logic [3:0] oe);
        int t0;
        @(negedge clk_in);
        txb = rnd();
        oph = 1'b1;
        t0 = ntk;
        i_sfb_host.xfer(8'h00, w, 1'b1, r);
        chk(r, txb);
        chk({4'h0, doe}, {4'h0, oe});
        chk(8'(ntk - t0), 8'h01);
        chk({7'h0, sel}, 8'h01);
        i_sfb_host.close;
        @(negedge clk_in) oph = 1'b0;
        chk({4'h0, doe}, 8'h00);
        chk({7'h0, sel}, 8'h00);
    endtask
    // Model comparison at every result, and the hang limit
    always @(negedge clk_in) begin
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            conclude;
        end
        if (cmd_v === 1'b1)
            chk(cmd_b, eq.size() ? eq.pop_front() : 'x);
        if (rx_v === 1'b1)
            chk(rx_b, rq.size() ? rq.pop_front() : 'x);
        if (srst === 1'b1) nsr++;
        if (take === 1'b1) ntk++;
        if (!rstn_in) seen_p <= 1'b0;
        else if (pau === 1'b1) seen_p <= 1'b1;
    end
    initial begin
        {rstn_in, quad_en, spb, wel, oph} = '0;
        txb = 8'h00;
        repeat (8) @(posedge clk_in);
        @(negedge clk_in) rstn_in = 1'b1;
        chk({4'h0, doe}, 8'h00);
        chk({7'h0, mode}, 8'h00);
        i_sfb_host.xfer(8'h11, 1, 1'b0, r);
        for (int m = 0; m < 2; m++) begin
            i_sfb_host.m3 = m[0];
            i_sfb_host.hold = !m[0];
            go(8'h10 | (rnd() & 8'h0f), 1);
            b = rnd();
            rq.push_back(b);
            i_sfb_host.xfer(b, 1, 1'b0, r);
            rd(1, 4'h2);
        end
        chk({7'h0, seen_p}, 8'h01);
        i_sfb_host.m3 = 1'b0;
        i_sfb_host.open;
        i_sfb_host.xfer(8'h6b, 1, 1'b0, r);
        i_sfb_host.close;
        op(8'h38, 1);
        chk({7'h0, mode}, 8'h00);
        @(negedge clk_in) quad_en = 1'b1;
        foreach (ops[k]) begin
            go(ops[k], 1);
            b = rnd();
            rq.push_back(b);
            i_sfb_host.xfer(b, k[0] ? (k < 2 ? 2 : 4) : 1, 1'b0, r);
            rd(k < 2 ? 2 : 4, k < 2 ? 4'h3 : 4'hf);
        end
        op(8'h38, 1);
        chk({7'h0, mode}, 8'h01);
        op(8'h10 | (rnd() & 8'h0f), 4);
        op(8'hff, 4);
        chk({7'h0, mode}, 8'h00);
        op(8'h38, 1);
        op(8'h99, 4);
        chk({7'h0, mode}, 8'h00);
        chk(nsr[7:0], 8'h01);
        for (int k = 0; k < 16; k++) begin
            @(negedge clk_in);
            {wel, spb, quad_en} = {k[3], k[2], k[0]};
            i_sfb_host.d_out[2] = k[1];
            repeat (10) @(negedge clk_in);
            chk({7'h0, allow}, {7'h0, k[3] & ~(k[2] & ~k[1] & ~k[0])});
        end
        chk(8'(eq.size() + rq.size()), 8'h00);
        conclude;
    end
endmodule
